/* common/lock_pkg.sv */
package lock_pkg;

   // ----------------------------------------------------------------
   // build-time sizes
   // ----------------------------------------------------------------
   localparam int unsigned DW       = 32;
   localparam int unsigned IW       = 8;
   localparam int unsigned NIRQ     = 32;
   localparam logic [4:0]  LOCK_CNT = 5'h08;

   // ----------------------------------------------------------------
   // register word indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [IW-1:0] OFS_DCTL = 8'h00;
   localparam logic [IW-1:0] OFS_TYPE = 8'h01;
   localparam logic [IW-1:0] OFS_CCTL = 8'h02;
   localparam logic [IW-1:0] OFS_PMR  = 8'h03;
   localparam logic [IW-1:0] OFS_RPR  = 8'h04;
   localparam logic [IW-1:0] OFS_STAT = 8'h05;
   localparam logic [IW-1:0] OFS_GRP  = 8'h20;
   localparam logic [IW-1:0] OFS_SEN  = 8'h21;
   localparam logic [IW-1:0] OFS_CEN  = 8'h22;
   localparam logic [IW-1:0] OFS_SPD  = 8'h23;
   localparam logic [IW-1:0] OFS_CPD  = 8'h24;
   localparam logic [IW-1:0] OFS_SAC  = 8'h25;
   localparam logic [IW-1:0] OFS_CAC  = 8'h26;
   localparam logic [IW-1:0] OFS_PRI  = 8'h28;
   localparam logic [IW-1:0] OFS_TGT  = 8'h30;
   localparam logic [IW-1:0] OFS_CFG  = 8'h38;
   localparam int unsigned   PRI_WORDS = 8;
   localparam int unsigned   CFG_WORDS = 2;

   // ----------------------------------------------------------------
   // field layouts and reset values
   // ----------------------------------------------------------------
   localparam int unsigned DCTL_G0     = 0;
   localparam int unsigned DCTL_G1     = 1;
   localparam int unsigned NS_EN_BIT   = 0;
   localparam int unsigned CCTL_G1     = 1;
   localparam int unsigned TYPE_SEC    = 10;
   localparam int unsigned TYPE_LCNT   = 11;
   localparam logic [DW-1:0] CCTL_IMPL = 32'h0000027f;
   localparam logic [DW-1:0] CCTL_LOCK = 32'h0000027d;
   localparam logic [DW-1:0] CCTL_RST  = 32'h00000000;
   localparam logic [7:0]    PMR_RST   = 8'h00;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_ACK  = 2'b10
   } bus_state_t;

   // ----------------------------------------------------------------
   // non-secure view of an 8-bit priority value
   // ----------------------------------------------------------------
   function automatic logic [7:0] ns_read_view(input logic [7:0] s);
      return {s[6:0], 1'b0};
   endfunction

   function automatic logic [7:0] ns_write_view(input logic [7:0] v);
      return {1'b1, v[7:1]};
   endfunction

endpackage

/* common/reg_req_if.sv */
interface reg_req_if;
   import lock_pkg::*;

   logic          wr;
   logic [IW-1:0] idx;
   logic [DW-1:0] wdata;
   logic [3:0]    sel;
   logic          ns;
   logic          lock;
   logic          g0_en;
   logic          g1_en;
   logic [7:0]    rprio;
   logic [DW-1:0] bank_rdata;
   logic [DW-1:0] pmr_rdata;

   modport ctrl (output wr, idx, wdata, sel, ns, lock, g0_en, g1_en, rprio,
                 input bank_rdata, pmr_rdata);
   modport bank (input wr, idx, wdata, sel, ns, lock, g0_en, g1_en,
                 output bank_rdata);
   modport mask (input wr, idx, wdata, ns, rprio, output pmr_rdata);

endinterface

/* hdl/prio_mask_view.sv */
module prio_mask_view (
   input  wire logic clk_i,
   input  wire logic rst_i,
   reg_req_if.mask   rq
);
   import lock_pkg::*;

   logic [7:0] pmr;
   logic [7:0] next_pmr;

   // ----------------------------------------------------------------
   // mask update
   // ----------------------------------------------------------------
   always_comb begin
      next_pmr = pmr;
      if (rq.wr && rq.idx == OFS_PMR) begin
         if (!rq.ns) begin
            next_pmr = rq.wdata[7:0];
         end else if (pmr[7]) begin
            next_pmr = ns_write_view(rq.wdata[7:0]);
         end
         // non-secure write with mask in secure half is dropped
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pmr <= PMR_RST;
      end else begin
         pmr <= next_pmr;
      end
   end

   // ----------------------------------------------------------------
   // read views of mask and running priority
   // ----------------------------------------------------------------
   always_comb begin
      rq.pmr_rdata = '0;
      if (rq.idx == OFS_PMR) begin
         if (!rq.ns) begin
            rq.pmr_rdata[7:0] = pmr;
         end else if (pmr[7]) begin
            rq.pmr_rdata[7:0] = ns_read_view(pmr);
         end
      end else if (rq.idx == OFS_RPR) begin
         if (!rq.ns) begin
            rq.pmr_rdata[7:0] = rq.rprio;
         end else if (pmr[7]) begin
            rq.pmr_rdata[7:0] = ns_read_view(rq.rprio);
         end
         // otherwise zero for non-secure
      end
   end

endmodule // prio_mask_view

/* hdl/irq_field_bank.sv */
module irq_field_bank (
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   reg_req_if.bank                     rq,
   output logic [lock_pkg::NIRQ-1:0]   forward_o
);
   import lock_pkg::*;

   logic [NIRQ-1:0] grp, en, pend, act, fwd;
   logic [NIRQ-1:0] next_grp, next_en, next_pend, next_act, next_fwd;
   logic [7:0]      prio [NIRQ];
   logic [7:0]      tgt  [NIRQ];
   logic [1:0]      cfg  [NIRQ];
   logic [7:0]      next_prio [NIRQ];
   logic [7:0]      next_tgt  [NIRQ];
   logic [1:0]      next_cfg  [NIRQ];

   // per-interrupt write permission, taken at the write itself
   function automatic logic may_write(input logic g, input int unsigned i);
      logic lockable;
      lockable = (i < 32'(LOCK_CNT));
      if (rq.lock && lockable && !g) begin
         return 1'b0;
      end
      return !(rq.ns && !g);
   endfunction

   // ----------------------------------------------------------------
   // field updates
   // ----------------------------------------------------------------
   always_comb begin
      int unsigned k;
      logic        ok;
      k         = 0;
      ok        = 1'b0;
      next_grp  = grp;
      next_en   = en;
      next_pend = pend;
      next_act  = act;
      next_prio = prio;
      next_tgt  = tgt;
      next_cfg  = cfg;
      for (int unsigned i = 0; i < NIRQ; i++) begin
         ok = may_write(grp[i], i) && rq.wr && rq.sel[i/8];
         if (rq.idx == OFS_GRP) begin
            if (ok && !rq.ns) next_grp[i] = rq.wdata[i];
         end else if (rq.idx == OFS_SEN) begin
            if (ok && rq.wdata[i]) next_en[i] = 1'b1;
         end else if (rq.idx == OFS_CEN) begin
            if (ok && rq.wdata[i]) next_en[i] = 1'b0;
         end else if (rq.idx == OFS_SPD) begin
            if (ok && rq.wdata[i]) next_pend[i] = 1'b1;
         end else if (rq.idx == OFS_CPD) begin
            if (ok && rq.wdata[i]) next_pend[i] = 1'b0;
         end else if (rq.idx == OFS_SAC) begin
            if (ok && rq.wdata[i]) next_act[i] = 1'b1;
         end else if (rq.idx == OFS_CAC) begin
            if (ok && rq.wdata[i]) next_act[i] = 1'b0;
         end
         ok = may_write(grp[i], i) && rq.wr && rq.sel[i%4];
         if (rq.idx == OFS_PRI + IW'(i/4)) begin
            if (ok) begin
               next_prio[i] = rq.ns ? ns_write_view(rq.wdata[8*(i%4)+:8])
                                    : rq.wdata[8*(i%4)+:8];
            end
         end else if (rq.idx == OFS_TGT + IW'(i/4)) begin
            if (ok) next_tgt[i] = rq.wdata[8*(i%4)+:8];
         end
         k = i % 16;
         ok = may_write(grp[i], i) && rq.wr && rq.sel[k/4];
         if (rq.idx == OFS_CFG + IW'(i/16) && ok) begin
            next_cfg[i] = rq.wdata[2*k+:2];
         end
      end
      for (int unsigned i = 0; i < NIRQ; i++) begin
         next_fwd[i] = next_pend[i] && next_en[i]
                    && (next_grp[i] ? rq.g1_en : rq.g0_en);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         grp  <= '0;
         en   <= '0;
         pend <= '0;
         act  <= '0;
         fwd  <= '0;
         for (int unsigned i = 0; i < NIRQ; i++) begin
            prio[i] <= '0;
            tgt[i]  <= '0;
            cfg[i]  <= '0;
         end
      end else begin
         grp  <= next_grp;
         en   <= next_en;
         pend <= next_pend;
         act  <= next_act;
         fwd  <= next_fwd;
         prio <= next_prio;
         tgt  <= next_tgt;
         cfg  <= next_cfg;
      end
   end

   assign forward_o = fwd;

   // ----------------------------------------------------------------
   // read data, group 0 fields hidden from non-secure
   // ----------------------------------------------------------------
   always_comb begin
      logic [NIRQ-1:0] vis;
      vis = rq.ns ? grp : '1;
      rq.bank_rdata = '0;
      if (rq.idx == OFS_GRP) begin
         rq.bank_rdata = rq.ns ? '0 : grp;
      end else if (rq.idx == OFS_SEN || rq.idx == OFS_CEN) begin
         rq.bank_rdata = en & vis;
      end else if (rq.idx == OFS_SPD || rq.idx == OFS_CPD) begin
         rq.bank_rdata = pend & vis;
      end else if (rq.idx == OFS_SAC || rq.idx == OFS_CAC) begin
         rq.bank_rdata = act & vis;
      end else begin
         for (int unsigned i = 0; i < NIRQ; i++) begin
            if (rq.idx == OFS_PRI + IW'(i/4) && vis[i]) begin
               rq.bank_rdata[8*(i%4)+:8] = rq.ns ? ns_read_view(prio[i])
                                                 : prio[i];
            end
            if (rq.idx == OFS_TGT + IW'(i/4) && vis[i]) begin
               rq.bank_rdata[8*(i%4)+:8] = tgt[i];
            end
            if (rq.idx == OFS_CFG + IW'(i/16) && vis[i]) begin
               rq.bank_rdata[2*(i%16)+:2] = cfg[i];
            end
         end
      end
   end

endmodule // irq_field_bank

/* hdl/secure_config_lockdown.sv */
// Design decisions made here: the register addresses and the Wishbone register port.
module secure_config_lockdown (
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   input  wire logic                    cyc_i,
   input  wire logic                    stb_i,
   input  wire logic                    we_i,
   input  wire logic [11:0]             adr_i,
   input  wire logic [lock_pkg::DW-1:0] dat_i,
   input  wire logic [3:0]              sel_i,
   input  wire logic                    ns_access_i,
   input  wire logic                    secure_cfg_lock_in_i,
   input  wire logic [7:0]              running_prio_i,
   output logic      [lock_pkg::DW-1:0] dat_o,
   output logic                         ack_o,
   output logic                         group0_forward_en_o,
   output logic                         group1_forward_en_o,
   output logic      [lock_pkg::DW-1:0] cpu_if_control_o,
   output logic                         lock_active_o,
   output logic    [lock_pkg::NIRQ-1:0] forward_pend_o
);
   import lock_pkg::*;

   reg_req_if rq ();

   bus_state_t    state;
   bus_state_t    next_state;
   logic          ack;
   logic          next_ack;
   logic [DW-1:0] rdata;
   logic [DW-1:0] next_rdata;
   logic          lock_meta;
   logic          lock_sync;
   logic          lock_eff;
   logic          next_lock_eff;
   logic          dctl_g0;
   logic          dctl_g1;
   logic          next_dctl_g0;
   logic          next_dctl_g1;
   logic [DW-1:0] cctl;
   logic [DW-1:0] next_cctl;
   logic [DW-1:0] cctl_mask;
   logic          req;
   logic          mapped;
   logic [DW-1:0] local_rdata;

   // ----------------------------------------------------------------
   // lock input synchroniser
   // ----------------------------------------------------------------
   always_comb begin
      next_lock_eff = lock_sync && (LOCK_CNT != 5'h00);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lock_meta <= 1'b0;
         lock_sync <= 1'b0;
         lock_eff  <= 1'b0;
      end else begin
         lock_meta <= secure_cfg_lock_in_i;
         lock_sync <= lock_meta;
         lock_eff  <= next_lock_eff;
      end
   end

   // ----------------------------------------------------------------
   // bus request decode
   // ----------------------------------------------------------------
   always_comb begin
      req    = cyc_i && stb_i && (state == ST_IDLE);
      mapped = (adr_i[11:10] == 2'b00) && (adr_i[1:0] == 2'b00);
   end

   assign rq.wr    = req && we_i && mapped;
   assign rq.idx   = adr_i[9:2];
   assign rq.wdata = dat_i;
   assign rq.sel   = sel_i;
   assign rq.ns    = ns_access_i;
   assign rq.lock  = lock_eff;
   assign rq.g0_en = dctl_g0;
   assign rq.g1_en = dctl_g1;
   assign rq.rprio = running_prio_i;

   // ----------------------------------------------------------------
   // sub-blocks
   // ----------------------------------------------------------------
   prio_mask_view u_mask (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .rq    (rq.mask)
   );

   irq_field_bank u_bank (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .rq        (rq.bank),
      .forward_o (forward_pend_o)
   );

   // ----------------------------------------------------------------
   // distributor and cpu-interface control
   // ----------------------------------------------------------------
   always_comb begin
      next_dctl_g0 = dctl_g0;
      next_dctl_g1 = dctl_g1;
      next_cctl    = cctl;
      cctl_mask    = CCTL_IMPL;
      if (lock_eff) begin
         cctl_mask = CCTL_IMPL & ~CCTL_LOCK;
      end
      if (rq.wr && rq.idx == OFS_DCTL) begin
         if (rq.ns) begin
            next_dctl_g1 = dat_i[NS_EN_BIT];
         end else begin
            next_dctl_g1 = dat_i[DCTL_G1];
            if (!lock_eff) begin
               next_dctl_g0 = dat_i[DCTL_G0];
            end
         end
      end
      if (rq.wr && rq.idx == OFS_CCTL) begin
         if (rq.ns) begin
            next_cctl[CCTL_G1] = dat_i[NS_EN_BIT];
         end else begin
            next_cctl = (cctl & ~cctl_mask) | (dat_i & cctl_mask);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dctl_g0 <= 1'b0;
         dctl_g1 <= 1'b0;
         cctl    <= CCTL_RST;
      end else begin
         dctl_g0 <= next_dctl_g0;
         dctl_g1 <= next_dctl_g1;
         cctl    <= next_cctl;
      end
   end

   // ----------------------------------------------------------------
   // local register read mux
   // ----------------------------------------------------------------
   always_comb begin
      local_rdata = '0;
      if (rq.idx == OFS_DCTL) begin
         if (ns_access_i) begin
            local_rdata[NS_EN_BIT] = dctl_g1;
         end else begin
            local_rdata[DCTL_G0] = dctl_g0;
            local_rdata[DCTL_G1] = dctl_g1;
         end
      end else if (rq.idx == OFS_TYPE) begin
         local_rdata[TYPE_SEC]              = 1'b1;
         local_rdata[TYPE_LCNT+:5]          = LOCK_CNT;
      end else if (rq.idx == OFS_CCTL) begin
         if (ns_access_i) begin
            local_rdata[NS_EN_BIT] = cctl[CCTL_G1];
         end else begin
            local_rdata = cctl;
         end
      end else if (rq.idx == OFS_STAT) begin
         local_rdata[0] = lock_eff;
         local_rdata[1] = lock_sync;
      end else begin
         local_rdata = rq.pmr_rdata | rq.bank_rdata;
      end
   end

   // ----------------------------------------------------------------
   // wishbone answer: one ack per request, never an error
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_ack   = 1'b0;
      next_rdata = rdata;
      case (state)
         ST_IDLE: begin
            if (req) begin
               next_state = ST_ACK;
               next_ack   = 1'b1;
               next_rdata = (mapped && !we_i) ? local_rdata : '0;
            end
         end
         ST_ACK: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= ST_IDLE;
         ack   <= 1'b0;
         rdata <= '0;
      end else begin
         state <= next_state;
         ack   <= next_ack;
         rdata <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign ack_o               = ack;
   assign dat_o               = rdata;
   assign group0_forward_en_o = dctl_g0;
   assign group1_forward_en_o = dctl_g1;
   assign cpu_if_control_o    = cctl;
   assign lock_active_o       = lock_eff;

endmodule // secure_config_lockdown

/* verif/wb_host_model.sv */
// ------------------------------------------------------------
// processor side: classic single-cycle bus master
// ------------------------------------------------------------
module wb_host_model (
   input  wire logic        clk_i,
   input  wire logic        ack_i,
   output logic             cyc_o,
   output logic             stb_o,
   output logic             we_o,
   output logic             ns_o,
   output logic [11:0]      adr_o,
   output logic [31:0]      dat_o,
   output logic [3:0]       sel_o
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o  = 1'b0;
      ns_o  = 1'b0;
      adr_o = 12'h000;
      dat_o = 32'h5a5a5a5a;
      sel_o = 4'h0;
   end

   // hold request until ack edge, then release; data inverted idle
   task automatic acc(input logic w, n, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o  <= w;
      ns_o  <= n;
      adr_o <= a;
      dat_o <= d;
      sel_o <= 4'hf;
      do @(posedge clk_i); while (ack_i !== 1'b1);
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      dat_o <= ~d;
   endtask
endmodule // wb_host_model

/* verif/secure_config_lockdown_asserts.sv */
module lock_checker
   import lock_pkg::*;
(
   input wire logic            clk_i,
   input wire logic            rst_i,
   input wire logic            cyc_i,
   input wire logic            stb_i,
   input wire logic            we_i,
   input wire logic [11:0]     adr_i,
   input wire logic [DW-1:0]   dat_i,
   input wire logic [3:0]      sel_i,
   input wire logic            ns_access_i,
   input wire logic            secure_cfg_lock_in_i,
   input wire logic [7:0]      running_prio_i,
   input wire logic [DW-1:0]   dat_o,
   input wire logic            ack_o,
   input wire logic            group0_forward_en_o,
   input wire logic            group1_forward_en_o,
   input wire logic [DW-1:0]   cpu_if_control_o,
   input wire logic            lock_active_o,
   input wire logic [NIRQ-1:0] forward_pend_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   logic       req;
   logic       wr_s;
   logic [2:0] since_rst;
   assign req  = cyc_i && stb_i && !ack_o;
   assign wr_s = req && we_i && !ns_access_i;

   always_ff @(posedge clk_i) begin
      if (rst_i) since_rst <= 3'h0;
      else if (since_rst != 3'h7) since_rst <= since_rst + 3'h1;
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   ack_latency_a: assert property (req |=> ack_o)
      else $error("no ack one cycle after request");
   ack_pulse_a: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   ack_cause_a: assert property (ack_o |-> $past(req))
      else $error("ack without request");
   lock_follow_a: assert property (since_rst == 3'h7 &&
      $stable(secure_cfg_lock_in_i)[*4] |->
      lock_active_o == secure_cfg_lock_in_i)
      else $error("lock state does not follow lock pin");
   g0_locked_a: assert property (wr_s && adr_i == 12'h000 &&
      lock_active_o ##1 lock_active_o |-> $stable(group0_forward_en_o))
      else $error("group0 enable changed under lock");
   g0_open_a: assert property (wr_s && adr_i == 12'h000 &&
      !lock_active_o ##1 !lock_active_o |->
      group0_forward_en_o == $past(dat_i[0]))
      else $error("secure group0 enable write lost");
   cctl_locked_a: assert property (wr_s && adr_i == 12'h008 &&
      lock_active_o ##1 lock_active_o |->
      $stable(cpu_if_control_o & CCTL_LOCK))
      else $error("locked cpu control bits changed");
   g1_ns_write_a: assert property (req && we_i && ns_access_i &&
      adr_i == 12'h000 |=> group1_forward_en_o == $past(dat_i[0]))
      else $error("non-secure enable write lost");
   ns_mask_view_a: assert property (req && !we_i && ns_access_i &&
      adr_i == 12'h00c |=> ack_o && dat_o[0] == 1'b0 && dat_o[31:8] == 0)
      else $error("non-secure mask read not in view form");
   type_count_a: assert property (req && !we_i &&
      adr_i == 12'h004 |=> dat_o[15:11] == LOCK_CNT && dat_o[10])
      else $error("type register count wrong");
   fwd_off_a: assert property (!group0_forward_en_o &&
      !group1_forward_en_o [*2] |-> forward_pend_o == 0)
      else $error("forwarding while both groups disabled");
endmodule // lock_checker

bind secure_config_lockdown lock_checker u_lock_checker (.*);

/* verif/tb_secure_config_lockdown.sv */
module tb_secure_config_lockdown;
   timeunit 1ns;
   timeprecision 1ps;
   import lock_pkg::*;

   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        lock = 1'b0;
   logic [7:0]  rprio = 8'h00;
   logic        cyc, stb, we, ns, ack;
   logic [11:0] adr;
   logic [31:0] wdat, rdat, r;
   logic [3:0]  sel;
   logic [63:0] exp_q[$];
   int          fail_count = 0;
   int          n_compared = 0;

   always #4 clk = ~clk;

   wb_host_model host (.clk_i(clk), .ack_i(ack), .cyc_o(cyc), .stb_o(stb),
      .we_o(we), .ns_o(ns), .adr_o(adr), .dat_o(wdat), .sel_o(sel));

   secure_config_lockdown DUT (.clk_i(clk), .rst_i(rst), .cyc_i(cyc),
      .stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(wdat), .sel_i(sel),
      .ns_access_i(ns), .secure_cfg_lock_in_i(lock),
      .running_prio_i(rprio), .dat_o(rdat), .ack_o(ack),
      .group0_forward_en_o(), .group1_forward_en_o(),
      .cpu_if_control_o(), .lock_active_o(), .forward_pend_o());

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic wr(input logic n, input logic [7:0] o,
                     input logic [31:0] d);
      host.acc(1'b1, n, {2'b00, o, 2'b00}, d);
   endtask

   task automatic rd(input logic n, input logic [7:0] o,
                     input logic [31:0] e, m);
      exp_q.push_back({e, m});
      host.acc(1'b0, n, {2'b00, o, 2'b00}, 32'h0);
   endtask

   task automatic cmp(input logic [31:0] e, m, g);
      n_compared++;
      if ((g & m) !== e) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, g & m, e);
      end
   endtask

   task automatic fin(input string s);
      $display("test %s done", s);
   endtask

   task automatic stop_test;
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // ------------------------------------------------------------
   // read monitor
   // ------------------------------------------------------------
   always @(posedge clk) begin
      logic [63:0] q;
      if (ack === 1'b1 && we === 1'b0 && exp_q.size() != 0) begin
         q = exp_q.pop_front();
         cmp(q[63:32], q[31:0], rdat);
      end
   end

   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      stop_test();
   end

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      r = 32'h5610c7f5;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd(0, OFS_CCTL, CCTL_RST, 32'hffffffff);
      rd(1, OFS_PMR, 32'h0, 32'hffffffff);
      rd(1, OFS_RPR, 32'h0, 32'hffffffff);
      wr(0, OFS_PMR, 32'h7f);
      wr(1, OFS_PMR, 32'hff);
      rd(0, OFS_PMR, 32'h7f, 32'hff);
      rd(1, OFS_PMR, 32'h0, 32'hffffffff);
      rd(0, 8'hff, 32'h0, 32'hffffffff);
      fin("low_mask");
      for (int i = 0; i < 6; i++) begin
         r = lfsr(r);
         @(posedge clk);
         rprio <= r[23:16];
         wr(0, OFS_PMR, {24'h0, 1'b1, r[6:0]});
         rd(1, OFS_PMR, {24'h0, r[6:0], 1'b0}, 32'hffffffff);
         rd(1, OFS_RPR, {24'h0, r[22:16], 1'b0}, 32'hffffffff);
         wr(1, OFS_PMR, {24'h0, r[15:8]});
         rd(0, OFS_PMR, {24'h0, 1'b1, r[15:9]}, 32'hff);
      end
      fin("high_mask");
      wr(0, OFS_DCTL, 32'h3);
      rd(1, OFS_DCTL, 32'h1, 32'hffffffff);
      wr(1, OFS_DCTL, 32'h0);
      rd(0, OFS_DCTL, 32'h1, 32'hffffffff);
      wr(1, OFS_DCTL, 32'hffffffff);
      rd(1, OFS_DCTL, 32'h1, 32'hffffffff);
      rd(0, OFS_DCTL, 32'h3, 32'hffffffff);
      fin("banked_control");
      rd(0, OFS_TYPE, {16'h0, LOCK_CNT, 1'b1, 10'h0}, 32'hfc00);
      wr(0, OFS_GRP, 32'h2);
      wr(1, OFS_GRP, 32'hffffffff);
      rd(0, OFS_GRP, 32'h2, 32'hffffffff);
      rd(1, OFS_GRP, 32'h0, 32'hffffffff);
      wr(1, OFS_PRI, 32'hffffffff);
      rd(0, OFS_PRI, 32'h0000ff00, 32'hffffffff);
      rd(1, OFS_PRI, 32'h0000fe00, 32'hffffffff);
      wr(0, OFS_SEN, 32'h3);
      wr(0, OFS_SPD, 32'h3);
      wr(0, OFS_DCTL, 32'h0);
      wr(0, OFS_DCTL, 32'h3);
      wr(0, OFS_CCTL, CCTL_IMPL);
      rd(0, OFS_CCTL, CCTL_IMPL, 32'hffffffff);
      @(posedge clk);
      lock <= 1'b1;
      repeat (4) @(posedge clk);
      rd(0, OFS_STAT, 32'h3, 32'h3);
      fin("boot");
      // lock stays high from here to the end of the run
      wr(0, OFS_DCTL, 32'h0);
      rd(0, OFS_DCTL, 32'h1, 32'hffffffff);
      wr(0, OFS_CCTL, 32'h0);
      rd(0, OFS_CCTL, CCTL_LOCK, 32'hffffffff);
      wr(0, OFS_CEN, 32'h3);
      rd(0, OFS_SEN, 32'h1, 32'hffffffff);
      wr(0, OFS_SEN, 32'h100);
      rd(0, OFS_SEN, 32'h101, 32'hffffffff);
      wr(0, OFS_GRP, 32'h0);
      rd(0, OFS_GRP, 32'h0, 32'hffffffff);
      wr(0, OFS_PRI, 32'h0);
      rd(0, OFS_PRI, 32'h0000ff00, 32'hffffffff);
      wr(0, OFS_GRP, 32'h3);
      rd(0, OFS_GRP, 32'h0, 32'hffffffff);
      rd(0, OFS_STAT, 32'h1, 32'h1);
      fin("lockdown");
      repeat (3) @(posedge clk);
      stop_test();
   end
endmodule // tb_secure_config_lockdown
